// *** verilog/pwm_deadtime_irq.sv ***
// non-overlap rise delay for pairs b and c, timer event flags and irq
//
// Behaviour
// RULE1 - b output rise delayed by upper nibble of b delay; falls pass at once
// RULE2 - bb output rise delayed by lower nibble of b delay register
// RULE3 - c output rise delayed by upper nibble of c delay register
// RULE4 - cb output rise delayed by lower nibble of c delay register
// RULE5 - bit 7 set on overflow (timer) or period match (pwm); w1c
// RULE6 - bit 6 set at counter bottom in back-to-back mode; w1c
// RULE7 - bit 5 set when counter equals a duty; w1c
// RULE8 - bit 4 set when counter equals b duty; w1c
// RULE9 - bit 3 set when counter equals c duty; w1c
// RULE10 - bit 2 set on capture, held until software writes one
// RULE11 - interrupt requested only where enable bit is one
// RULE12 - delay counts pwm cycles; zero adds none; writing zero keeps flag
`timescale 1ns/1ns
module pwm_deadtime_irq #(
  parameter int PWM_DIV = pwm_dt_pkg::PWM_DIV_DEFAULT
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [pwm_dt_pkg::ADDR_W-1:0] addr_in,
  input wire logic [pwm_dt_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [pwm_dt_pkg::DATA_W-1:0] rdata_out,
  input wire logic pwm_mode_in,
  input wire logic b2b_mode_in,
  input wire logic overflow_evt_in,
  input wire logic period_match_evt_in,
  input wire logic bottom_evt_in,
  input wire logic a_match_evt_in,
  input wire logic b_match_evt_in,
  input wire logic c_match_evt_in,
  input wire logic capture_evt_in,
  input wire logic b_raw_in,
  input wire logic bb_raw_in,
  input wire logic c_raw_in,
  input wire logic cb_raw_in,
  output logic b_out,
  output logic bb_out,
  output logic c_out,
  output logic cb_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // parameter check

  if (PWM_DIV < 1 || PWM_DIV > pwm_dt_pkg::PWM_DIV_MAX) begin : g_div_chk
    $error("PWM_DIV must lie in 1..256");
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm clock enable

  logic [7:0] div_cnt_q;
  logic pwm_tick_q;

  // one-cycle enable; with PWM_DIV of 1 it is high every cycle
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      div_cnt_q <= 8'h00;
      pwm_tick_q <= 1'b0;
    end else if (div_cnt_q == 8'(PWM_DIV - 1)) begin
      div_cnt_q <= 8'h00;
      pwm_tick_q <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
      pwm_tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register decode

  logic pair_b_hit;
  logic pair_c_hit;
  logic flags_hit;
  logic enables_hit;

  always_comb begin
    pair_b_hit = 1'b0;
    pair_c_hit = 1'b0;
    flags_hit = 1'b0;
    enables_hit = 1'b0;
    if (addr_in == pwm_dt_pkg::PAIR_B_EDGE_DELAY_OFS) begin
      pair_b_hit = 1'b1;
    end else if (addr_in == pwm_dt_pkg::PAIR_C_EDGE_DELAY_OFS) begin
      pair_c_hit = 1'b1;
    end else if (addr_in == pwm_dt_pkg::TIMER_EVENT_FLAGS_OFS) begin
      flags_hit = 1'b1;
    end else if (addr_in == pwm_dt_pkg::TIMER_EVENT_ENABLES_OFS) begin
      enables_hit = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // delay registers

  logic [7:0] pair_b_edge_delay_q;
  logic [7:0] pair_c_edge_delay_q;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pair_b_edge_delay_q <= pwm_dt_pkg::PAIR_B_EDGE_DELAY_RST;
      pair_c_edge_delay_q <= pwm_dt_pkg::PAIR_C_EDGE_DELAY_RST;
    end else if (wr_in && pair_b_hit) begin
      pair_b_edge_delay_q <= wdata_in;
    end else if (wr_in && pair_c_hit) begin
      pair_c_edge_delay_q <= wdata_in;
    end
  end

  logic [3:0] b_rise_delay;
  logic [3:0] b_comp_rise_delay;
  logic [3:0] c_rise_delay;
  logic [3:0] c_comp_rise_delay;

  assign b_rise_delay = pair_b_edge_delay_q[pwm_dt_pkg::DLY_TRUE_LSB +: 4];
  assign b_comp_rise_delay =
    pair_b_edge_delay_q[pwm_dt_pkg::DLY_COMP_LSB +: 4];
  assign c_rise_delay = pair_c_edge_delay_q[pwm_dt_pkg::DLY_TRUE_LSB +: 4];
  assign c_comp_rise_delay =
    pair_c_edge_delay_q[pwm_dt_pkg::DLY_COMP_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////
  // delay lines

  rise_delay u_b_dly ( // see RULE1
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .tick_in(pwm_tick_q),
    .raw_in(b_raw_in),
    .dly_in(b_rise_delay),
    .out_out(b_out)
  );

  rise_delay u_bb_dly ( // see RULE2
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .tick_in(pwm_tick_q),
    .raw_in(bb_raw_in),
    .dly_in(b_comp_rise_delay),
    .out_out(bb_out)
  );

  rise_delay u_c_dly ( // see RULE3
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .tick_in(pwm_tick_q),
    .raw_in(c_raw_in),
    .dly_in(c_rise_delay),
    .out_out(c_out)
  );

  rise_delay u_cb_dly ( // see RULE4
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .tick_in(pwm_tick_q),
    .raw_in(cb_raw_in),
    .dly_in(c_comp_rise_delay),
    .out_out(cb_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // event flags

  logic [7:0] evt_set;
  logic [7:0] flag_clr;
  logic [7:0] timer_event_flags_q;
  logic [7:0] timer_event_flags_d;

  always_comb begin
    evt_set = 8'h00;
    evt_set[pwm_dt_pkg::OVERFLOW_FLAG_BIT] =
      (overflow_evt_in && !pwm_mode_in) ||
      (period_match_evt_in && pwm_mode_in); // see RULE5
    evt_set[pwm_dt_pkg::BOTTOM_FLAG_BIT] =
      bottom_evt_in && b2b_mode_in; // see RULE6
    evt_set[pwm_dt_pkg::A_MATCH_FLAG_BIT] = a_match_evt_in; // see RULE7
    evt_set[pwm_dt_pkg::B_MATCH_FLAG_BIT] = b_match_evt_in; // see RULE8
    evt_set[pwm_dt_pkg::C_MATCH_FLAG_BIT] = c_match_evt_in; // see RULE9
    evt_set[pwm_dt_pkg::CAPTURE_FLAG_BIT] = capture_evt_in; // see RULE10
  end

  // zeros in the write data clear nothing
  assign flag_clr = (wr_in && flags_hit) ? wdata_in : 8'h00; // see RULE12

  // a set in the clearing cycle wins, so no event is lost
  assign timer_event_flags_d =
    ((timer_event_flags_q & ~flag_clr) | evt_set) &
    pwm_dt_pkg::FLAG_IMPL_MASK;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      timer_event_flags_q <= pwm_dt_pkg::TIMER_EVENT_FLAGS_RST;
    end else begin
      timer_event_flags_q <= timer_event_flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enables and interrupt

  logic [7:0] timer_event_enables_q;
  logic [7:0] timer_event_enables_d;
  logic irq_q;

  assign timer_event_enables_d = (wr_in && enables_hit) ?
    wdata_in : timer_event_enables_q;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      timer_event_enables_q <= pwm_dt_pkg::TIMER_EVENT_ENABLES_RST;
    end else begin
      timer_event_enables_q <= timer_event_enables_d;
    end
  end

  // built from next values so the pin tracks the flags with no lag
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(timer_event_flags_d & timer_event_enables_d); // see RULE11
    end
  end

  assign irq_out = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // read port

  logic [7:0] rdata_q;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rdata_q <= pwm_dt_pkg::READ_UNMAPPED;
    end else if (rd_in && pair_b_hit) begin
      rdata_q <= pair_b_edge_delay_q;
    end else if (rd_in && pair_c_hit) begin
      rdata_q <= pair_c_edge_delay_q;
    end else if (rd_in && flags_hit) begin
      rdata_q <= timer_event_flags_q;
    end else if (rd_in && enables_hit) begin
      rdata_q <= timer_event_enables_q;
    end else begin
      rdata_q <= pwm_dt_pkg::READ_UNMAPPED;
    end
  end

  assign rdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb_clk @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  b_fall_pass_a: assert property ( // see RULE1
    $fell(b_raw_in) |=> !b_out)
    else $error("b output did not fall at once");

  bb_fall_pass_a: assert property ( // see RULE2
    $fell(bb_raw_in) |=> !bb_out)
    else $error("bb output did not fall at once");

  c_rise_hold_a: assert property ( // see RULE3
    ($rose(c_raw_in) && c_rise_delay != 4'h0) |=> !c_out)
    else $error("c output rose before its delay");

  cb_rise_zero_a: assert property ( // see RULE4
    ($rose(cb_raw_in) && c_comp_rise_delay == 4'h0) |=> cb_out)
    else $error("cb output not undelayed with zero delay");

  b_rise_one_a: assert property ( // see RULE12
    ($rose(b_raw_in) && b_rise_delay == 4'h1 && PWM_DIV == 1) |=>
    !b_out ##1 (b_out || !$past(b_raw_in) || !$past(pwm_tick_q)))
    else $error("b rise not one pwm cycle late");

  overflow_set_a: assert property ( // see RULE5
    ((overflow_evt_in && !pwm_mode_in) ||
     (period_match_evt_in && pwm_mode_in)) |=>
    timer_event_flags_q[pwm_dt_pkg::OVERFLOW_FLAG_BIT])
    else $error("overflow flag not set");

  bottom_set_a: assert property ( // see RULE6
    (bottom_evt_in && b2b_mode_in) |=>
    timer_event_flags_q[pwm_dt_pkg::BOTTOM_FLAG_BIT])
    else $error("bottom flag not set");

  match_flags_a: assert property ( // see RULE7
    (a_match_evt_in && b_match_evt_in && c_match_evt_in) |=>
    (timer_event_flags_q[5:3] == 3'h7))
    else $error("match flags not all set");

  b_match_set_a: assert property ( // see RULE8
    b_match_evt_in |=>
    timer_event_flags_q[pwm_dt_pkg::B_MATCH_FLAG_BIT])
    else $error("b match flag not set");

  c_match_clr_a: assert property ( // see RULE9
    (wr_in && flags_hit && wdata_in[pwm_dt_pkg::C_MATCH_FLAG_BIT] &&
     !c_match_evt_in) |=>
    !timer_event_flags_q[pwm_dt_pkg::C_MATCH_FLAG_BIT])
    else $error("c match flag not cleared by one");

  capture_hold_a: assert property ( // see RULE10
    (timer_event_flags_q[pwm_dt_pkg::CAPTURE_FLAG_BIT] &&
     !(wr_in && flags_hit)) |=>
    timer_event_flags_q[pwm_dt_pkg::CAPTURE_FLAG_BIT])
    else $error("capture flag dropped without a write");

  irq_gate_a: assert property ( // see RULE11
    irq_out == |(timer_event_flags_q & timer_event_enables_q))
    else $error("irq does not match enabled flags");

  zero_write_a: assert property ( // see RULE12
    (wr_in && flags_hit && wdata_in == 8'h00) |=>
    ((timer_event_flags_q & ~$past(timer_event_flags_q) &
      ~$past(evt_set)) == 8'h00) &&
    ((timer_event_flags_q & $past(timer_event_flags_q)) ==
     $past(timer_event_flags_q)))
    else $error("zero write cleared a flag");

  irq_seen_c: cover property (!irq_out ##1 irq_out);

  b_delayed_c: cover property (
    ($rose(b_raw_in) && b_rise_delay == 4'h3) ##[1:64] $rose(b_out));

  capture_clear_c: cover property (
    timer_event_flags_q[pwm_dt_pkg::CAPTURE_FLAG_BIT] ##1
    !timer_event_flags_q[pwm_dt_pkg::CAPTURE_FLAG_BIT]);

endmodule

// *** verilog/pwm_dt_pkg.sv ***
// shared constants for the non-overlap delay and event flag block
package pwm_dt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DLY_W = 4;

  // register offsets
  localparam logic [7:0] PAIR_B_EDGE_DELAY_OFS = 8'hc2;
  localparam logic [7:0] PAIR_C_EDGE_DELAY_OFS = 8'hc3;
  localparam logic [7:0] TIMER_EVENT_FLAGS_OFS = 8'hc4;
  localparam logic [7:0] TIMER_EVENT_ENABLES_OFS = 8'hc5;

  // reset values
  localparam logic [7:0] PAIR_B_EDGE_DELAY_RST = 8'h00;
  localparam logic [7:0] PAIR_C_EDGE_DELAY_RST = 8'h00;
  localparam logic [7:0] TIMER_EVENT_FLAGS_RST = 8'h00;
  localparam logic [7:0] TIMER_EVENT_ENABLES_RST = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // delay register nibbles: true output high, complement low
  localparam int DLY_TRUE_LSB = 4;
  localparam int DLY_COMP_LSB = 0;

  // flag and enable bit positions
  localparam int OVERFLOW_FLAG_BIT = 7;
  localparam int BOTTOM_FLAG_BIT = 6;
  localparam int A_MATCH_FLAG_BIT = 5;
  localparam int B_MATCH_FLAG_BIT = 4;
  localparam int C_MATCH_FLAG_BIT = 3;
  localparam int CAPTURE_FLAG_BIT = 2;

  // unused low bits of the flag register never set
  localparam logic [7:0] FLAG_IMPL_MASK = 8'hfc;

  // system clock cycles per pwm clock cycle
  localparam int PWM_DIV_DEFAULT = 1;
  localparam int PWM_DIV_MAX = 256;

  typedef enum logic [1:0] {
    DLY_IDLE,
    DLY_WAIT,
    DLY_HIGH
  } dly_state_t;

endpackage

// *** verilog/rise_delay.sv ***
// rising-edge-only delay line for one pwm output
`timescale 1ns/1ns
module rise_delay (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic tick_in,
  input wire logic raw_in,
  input wire logic [pwm_dt_pkg::DLY_W-1:0] dly_in,
  output logic out_out
);

  pwm_dt_pkg::dly_state_t state_q;
  logic [pwm_dt_pkg::DLY_W-1:0] cnt_q;
  logic out_q;

  assign out_out = out_q;

  // falling input wins at once; a rise waits dly_in pwm ticks
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_q <= pwm_dt_pkg::DLY_IDLE;
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (!raw_in) begin
      state_q <= pwm_dt_pkg::DLY_IDLE;
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      case (state_q)
        pwm_dt_pkg::DLY_IDLE: begin
          // delay sampled at the edge, later writes act next edge
          if (dly_in == '0) begin
            state_q <= pwm_dt_pkg::DLY_HIGH;
            out_q <= 1'b1;
          end else begin
            state_q <= pwm_dt_pkg::DLY_WAIT;
            cnt_q <= dly_in;
          end
        end
        pwm_dt_pkg::DLY_WAIT: begin
          if (tick_in) begin
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == 4'h1) begin
              state_q <= pwm_dt_pkg::DLY_HIGH;
              out_q <= 1'b1;
            end
          end
        end
        default: begin
          out_q <= 1'b1;
        end
      endcase
    end
  end

endmodule

// *** dv/pwm_deadtime_and_irq_status_bench.sv ***
// self-checking bench for the rise delay and event flag block
`timescale 1ns/1ns
module pwm_deadtime_and_irq_status_bench;
  logic mclk_in;
  logic srst_in;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic pwm_mode;
  logic b2b_mode;
  logic [6:0] ev;
  logic [3:0] raw;
  wire [7:0] rdata;
  wire [3:0] dout;
  wire irq;
  int err_count;
  int n_compared;
  int seed;
  logic [7:0] rv;
  logic [7:0] en;
  logic [7:0] ex;
  logic [7:0] rst_tab [5];

  ////////////////////////////////////////////////////////////////////////////
  // pwm divider of one so expected rise lag is delay plus one cycle
  pwm_deadtime_irq #(.PWM_DIV(1)) i_dut (
    .mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .pwm_mode_in(pwm_mode), .b2b_mode_in(b2b_mode),
    .overflow_evt_in(ev[0]), .period_match_evt_in(ev[1]),
    .bottom_evt_in(ev[2]), .a_match_evt_in(ev[3]),
    .b_match_evt_in(ev[4]), .c_match_evt_in(ev[5]),
    .capture_evt_in(ev[6]), .b_raw_in(raw[0]), .bb_raw_in(raw[1]),
    .c_raw_in(raw[2]), .cb_raw_in(raw[3]), .b_out(dout[0]),
    .bb_out(dout[1]), .c_out(dout[2]), .cb_out(dout[3]), .irq_out(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // expected flag for event j; mode inputs gate overflow, period, bottom
  function automatic logic [7:0] flag_of(int j, logic pm, logic bb);
    case (j)
      0: flag_of = pm ? 8'h00 : 8'h01 << pwm_dt_pkg::OVERFLOW_FLAG_BIT;
      1: flag_of = pm ? 8'h01 << pwm_dt_pkg::OVERFLOW_FLAG_BIT : 8'h00;
      2: flag_of = bb ? 8'h01 << pwm_dt_pkg::BOTTOM_FLAG_BIT : 8'h00;
      3: flag_of = 8'h01 << pwm_dt_pkg::A_MATCH_FLAG_BIT;
      4: flag_of = 8'h01 << pwm_dt_pkg::B_MATCH_FLAG_BIT;
      5: flag_of = 8'h01 << pwm_dt_pkg::C_MATCH_FLAG_BIT;
      default: flag_of = 8'h01 << pwm_dt_pkg::CAPTURE_FLAG_BIT;
    endcase
  endfunction

  // true outputs use the upper nibble, complements the lower
  function automatic int dly_of(int i, logic [7:0] r);
    dly_of = (i % 2 == 0) ? int'(r[7:4]) : int'(r[3:0]);
  endfunction

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(logic [7:0] a, logic [7:0] v);
    @(posedge mclk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask

  // read data only stands the cycle after the strobe
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic delay_case(int i, logic [7:0] r, bit abort);
    int dd;
    dd = dly_of(i, r);
    wr_reg(i < 2 ? pwm_dt_pkg::PAIR_B_EDGE_DELAY_OFS :
           pwm_dt_pkg::PAIR_C_EDGE_DELAY_OFS, r);
    @(posedge mclk_in);
    raw[i] <= 1'b1;
    if (abort) begin
      @(posedge mclk_in);
      raw[i] <= 1'b0;
      repeat (18) begin
        @(posedge mclk_in);
        #1;
        chk({7'h0, dout[i]}, 8'h00);
      end
    end else begin
      for (int k = 1; k <= dd + 1; k++) begin
        @(posedge mclk_in);
        #1;
        chk({7'h0, dout[i]}, {7'h0, k == dd + 1});
      end
      @(posedge mclk_in);
      raw[i] <= 1'b0;
      @(posedge mclk_in);
      #1;
      chk({7'h0, dout[i]}, 8'h00);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  // hang guard well beyond the longest sequence
  initial begin
    #400000;
    err_count++;
    final_report();
  end

  initial begin
    seed = 63;
    err_count = 0;
    n_compared = 0;
    srst_in = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    pwm_mode = 1'b0;
    b2b_mode = 1'b0;
    ev = 7'h00;
    raw = 4'h0;
    rst_tab = '{pwm_dt_pkg::PAIR_B_EDGE_DELAY_RST,
                pwm_dt_pkg::PAIR_C_EDGE_DELAY_RST,
                pwm_dt_pkg::TIMER_EVENT_FLAGS_RST,
                pwm_dt_pkg::TIMER_EVENT_ENABLES_RST,
                pwm_dt_pkg::READ_UNMAPPED};
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    #1;
    chk({dout, 3'h0, irq}, 8'h00);
    for (int k = 0; k < 5; k++) begin
      rd_chk(8'hc2 + 8'(k), rst_tab[k]);
    end
    @(posedge mclk_in);
    #1;
    chk(rdata, 8'h00);
    // unmapped write must not land in the pair c delay register
    rv = 8'($random(seed));
    wr_reg(pwm_dt_pkg::PAIR_C_EDGE_DELAY_OFS, rv);
    wr_reg(8'hc6, 8'hff);
    rd_chk(8'hc6, pwm_dt_pkg::READ_UNMAPPED);
    rd_chk(pwm_dt_pkg::PAIR_C_EDGE_DELAY_OFS, rv);
    // corners zero and fifteen, then one, then random, then an aborted wait
    for (int i = 0; i < 4; i++) begin
      for (int c = 0; c < 6; c++) begin
        rv = c == 0 ? 8'h00 : c == 1 ? 8'hff : c == 2 ? 8'h11 :
             8'($random(seed));
        delay_case(i, rv, 1'b0);
      end
      rv = 8'($random(seed)) | 8'h22;
      delay_case(i, rv, 1'b1);
    end
    // every event in all four mode settings, random enables
    for (int m = 0; m < 4; m++) begin
      for (int j = 0; j < 7; j++) begin
        en = 8'($random(seed));
        wr_reg(pwm_dt_pkg::TIMER_EVENT_ENABLES_OFS, en);
        rd_chk(pwm_dt_pkg::TIMER_EVENT_ENABLES_OFS, en);
        ex = flag_of(j, m[0], m[1]);
        @(posedge mclk_in);
        pwm_mode <= m[0];
        b2b_mode <= m[1];
        ev[j] <= 1'b1;
        @(posedge mclk_in);
        ev[j] <= 1'b0;
        #1;
        chk({7'h0, irq}, {7'h0, |(ex & en)});
        rd_chk(pwm_dt_pkg::TIMER_EVENT_FLAGS_OFS, ex);
        wr_reg(pwm_dt_pkg::TIMER_EVENT_FLAGS_OFS, 8'h00);
        rd_chk(pwm_dt_pkg::TIMER_EVENT_FLAGS_OFS, ex);
        wr_reg(pwm_dt_pkg::TIMER_EVENT_ENABLES_OFS, 8'hff);
        #1;
        chk({7'h0, irq}, {7'h0, |ex});
        wr_reg(pwm_dt_pkg::TIMER_EVENT_FLAGS_OFS, ex);
        #1;
        chk({7'h0, irq}, 8'h00);
        rd_chk(pwm_dt_pkg::TIMER_EVENT_FLAGS_OFS, 8'h00);
      end
    end
    // matches and capture beside a capture clear: the set must survive
    ex = flag_of(3, 1'b0, 1'b0) | flag_of(4, 1'b0, 1'b0) |
         flag_of(5, 1'b0, 1'b0) | flag_of(6, 1'b0, 1'b0);
    @(posedge mclk_in);
    ev <= 7'h78;
    addr <= pwm_dt_pkg::TIMER_EVENT_FLAGS_OFS;
    wdata <= 8'h04;
    wr <= 1'b1;
    @(posedge mclk_in);
    ev <= 7'h00;
    wr <= 1'b0;
    rd_chk(pwm_dt_pkg::TIMER_EVENT_FLAGS_OFS, ex);
    // reset in mid-run clears flags, delays and the interrupt
    @(posedge mclk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'b0;
    #1;
    chk({dout, 3'h0, irq}, 8'h00);
    rd_chk(pwm_dt_pkg::TIMER_EVENT_FLAGS_OFS,
           pwm_dt_pkg::TIMER_EVENT_FLAGS_RST);
    rd_chk(pwm_dt_pkg::PAIR_B_EDGE_DELAY_OFS,
           pwm_dt_pkg::PAIR_B_EDGE_DELAY_RST);
    final_report();
  end
endmodule
